// *** inc/coil_bank_consts.svh ***
`ifndef COIL_BANK_CONSTS_SVH
`define COIL_BANK_CONSTS_SVH

// function codes served by the bank
`define FUNC_READ_COILS   8'h01
`define FUNC_WRITE_COIL   8'h05
`define FUNC_WRITE_REG    8'h06

// exception codes
`define EXC_NONE          8'h00
`define EXC_FUNC          8'h01
`define EXC_ADDR          8'h02
`define EXC_DATA          8'h03
`define EXC_BUSY          8'h22

// single-coil write values and read quantity
`define COIL_ON_VALUE     16'hFF00
`define COIL_OFF_VALUE    16'h0000
`define READ_QUANTITY     16'h0001

// wire address is one below the listed number
`define ADDR_TO_NUMBER    16'h0001

// writable coils
`define COIL_RUN          16'h0001
`define COIL_REVERSE      16'h0002
`define COIL_EXT_TRIP     16'h0003
`define COIL_TRIP_RESET   16'h0004
`define COIL_VIN_FIRST    16'h0007
`define COIL_VIN_LAST     16'h000B

// read-only coils
`define COIL_RUN_STATE    16'h000F
`define COIL_DIR_STATE    16'h0010
`define COIL_READY_A      16'h0011
`define COIL_RUNNING      16'h0013
`define COIL_SPEED_REACH  16'h0014
`define COIL_OVERREACH    16'h0015
`define COIL_OVERLOAD     16'h0016
`define COIL_DEVIATION    16'h0017
`define COIL_ALARM        16'h0018
`define COIL_SET_REACH    16'h0019
`define COIL_UNDERVOLT    16'h001C
`define COIL_RUNTIME      16'h001E
`define COIL_POWERON      16'h001F
`define COIL_THERMAL      16'h0020
`define COIL_ZERO_HZ      16'h0028
`define COIL_ANALOG_DISC  16'h002E
`define COIL_START_CONT   16'h003C
`define COIL_HEATSINK     16'h003D
`define COIL_LOW_CURRENT  16'h003E
`define COIL_READY_B      16'h0045
`define COIL_FWD_RUN      16'h0046
`define COIL_REV_RUN      16'h0047
`define COIL_MAJOR_FAIL   16'h0048
`define COIL_ERR_CRC      16'h004A
`define COIL_ERR_OVERRUN  16'h004B
`define COIL_ERR_FRAMING  16'h004C
`define COIL_ERR_PARITY   16'h004D
`define COIL_WINDOW_CMP   16'h0050
`define COIL_FREQ_PANEL   16'h0054
`define COIL_RUN_PANEL    16'h0055
`define COIL_SECOND_MOTOR 16'h0056

// holding register for the recalculation trigger
`define REG_RECALC        16'h0900
`define RECALC_VALUE      16'h0000

// settings
`define RUN_SRC_COMM      8'h03
`define RESET_SEL_TRIP    8'h02

`endif

// *** inc/coil_bank_pkg.sv ***
package coil_bank_pkg;

  // one decoded request from the frame handler
  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } request_type;

  // answer to the frame handler
  typedef struct packed {
    logic       ok;
    logic [7:0] exc_code;
    logic       rbit;
  } answer_type;

  // writable coil bank
  typedef struct packed {
    logic       run;
    logic       reverse;
    logic       external_trip_coil;
    logic       trip_reset_coil;
    logic [4:0] vin;
  } coils_type;

  // sticky communication error flags
  typedef struct packed {
    logic crc;
    logic overrun;
    logic framing;
    logic parity;
  } comm_error_type;

  // live device status shown on read-only coils
  typedef struct packed {
    logic run_state;
    logic direction_monitor;
    logic inverter_ready_flag;
    logic running;
    logic speed_reached_flag;
    logic freq_overreach_flag;
    logic overload_notice_flag;
    logic pid_deviation_flag;
    logic alarm_flag;
    logic set_freq_reached_flag;
    logic undervoltage_flag;
    logic runtime_over_flag;
    logic poweron_time_over_flag;
    logic thermal_alarm_flag;
    logic zero_hz_flag;
    logic analog_disconnect_flag;
    logic start_contact_flag;
    logic heatsink_overheat_flag;
    logic low_current_flag;
    logic forward_running_flag;
    logic reverse_running_flag;
    logic major_failure_flag;
    logic window_compare_flag;
    logic freq_source_panel_flag;
    logic run_source_panel_flag;
    logic second_motor_flag;
  } device_status_type;

  // kind of access requested
  typedef enum logic [1:0] {
    ACC_READ,
    ACC_WRITE_COIL,
    ACC_WRITE_REG,
    ACC_BAD
  } access_type;

endpackage

// *** rtl/comm_error_flags.sv ***
`timescale 1ns/1ps
`include "coil_bank_consts.svh"

// sticky error flags; a detection in the clearing cycle is kept
module comm_error_flags (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire coil_bank_pkg::comm_error_type detect,
  input  wire logic                        clear,
  output coil_bank_pkg::comm_error_type    flags
);

  coil_bank_pkg::comm_error_type flags_q;
  coil_bank_pkg::comm_error_type flags_d;

  // set wins over clear
  assign flags_d = detect | (clear ? '0 : flags_q);

  // flag register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else if (ce) begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule

// *** rtl/coil_read_mux.sv ***
`timescale 1ns/1ps
`include "coil_bank_consts.svh"

// coil number to bit lookup; flags which numbers exist and which are writable
module coil_read_mux (
  input  wire logic [15:0]                     num,
  input  wire coil_bank_pkg::device_status_type st,
  input  wire coil_bank_pkg::comm_error_type    err,
  input  wire coil_bank_pkg::coils_type         coils,
  output logic                                 hit,
  output logic                                 rbit,
  output logic                                 writable
);

  // returns {hit, bit}
  function automatic logic [1:0] lookup(input logic [15:0] n,
                                        input coil_bank_pkg::device_status_type s,
                                        input coil_bank_pkg::comm_error_type e,
                                        input coil_bank_pkg::coils_type c);
    logic [15:0] vi;
    vi = 16'(n - `COIL_VIN_FIRST);
    case (n)
      `COIL_RUN:          lookup = {1'b1, c.run};
      `COIL_REVERSE:      lookup = {1'b1, c.reverse};
      `COIL_EXT_TRIP:     lookup = {1'b1, c.external_trip_coil};
      `COIL_TRIP_RESET:   lookup = {1'b1, c.trip_reset_coil};
      16'h0007, 16'h0008, 16'h0009, 16'h000A, 16'h000B:
                          lookup = {1'b1, c.vin[vi[2:0]]};
      `COIL_RUN_STATE:    lookup = {1'b1, s.run_state};
      `COIL_DIR_STATE:    lookup = {1'b1, s.direction_monitor};
      `COIL_READY_A,
      `COIL_READY_B:      lookup = {1'b1, s.inverter_ready_flag};
      `COIL_RUNNING:      lookup = {1'b1, s.running};
      `COIL_SPEED_REACH:  lookup = {1'b1, s.speed_reached_flag};
      `COIL_OVERREACH:    lookup = {1'b1, s.freq_overreach_flag};
      `COIL_OVERLOAD:     lookup = {1'b1, s.overload_notice_flag};
      `COIL_DEVIATION:    lookup = {1'b1, s.pid_deviation_flag};
      `COIL_ALARM:        lookup = {1'b1, s.alarm_flag};
      `COIL_SET_REACH:    lookup = {1'b1, s.set_freq_reached_flag};
      `COIL_UNDERVOLT:    lookup = {1'b1, s.undervoltage_flag};
      `COIL_RUNTIME:      lookup = {1'b1, s.runtime_over_flag};
      `COIL_POWERON:      lookup = {1'b1, s.poweron_time_over_flag};
      `COIL_THERMAL:      lookup = {1'b1, s.thermal_alarm_flag};
      `COIL_ZERO_HZ:      lookup = {1'b1, s.zero_hz_flag};
      `COIL_ANALOG_DISC:  lookup = {1'b1, s.analog_disconnect_flag};
      `COIL_START_CONT:   lookup = {1'b1, s.start_contact_flag};
      `COIL_HEATSINK:     lookup = {1'b1, s.heatsink_overheat_flag};
      `COIL_LOW_CURRENT:  lookup = {1'b1, s.low_current_flag};
      `COIL_FWD_RUN:      lookup = {1'b1, s.forward_running_flag};
      `COIL_REV_RUN:      lookup = {1'b1, s.reverse_running_flag};
      `COIL_MAJOR_FAIL:   lookup = {1'b1, s.major_failure_flag};
      `COIL_ERR_CRC:      lookup = {1'b1, e.crc};
      `COIL_ERR_OVERRUN:  lookup = {1'b1, e.overrun};
      `COIL_ERR_FRAMING:  lookup = {1'b1, e.framing};
      `COIL_ERR_PARITY:   lookup = {1'b1, e.parity};
      `COIL_WINDOW_CMP:   lookup = {1'b1, s.window_compare_flag};
      `COIL_FREQ_PANEL:   lookup = {1'b1, s.freq_source_panel_flag};
      `COIL_RUN_PANEL:    lookup = {1'b1, s.run_source_panel_flag};
      `COIL_SECOND_MOTOR: lookup = {1'b1, s.second_motor_flag};
      default:            lookup = 2'h0; // reserved numbers, 0000h among them
    endcase
  endfunction

  wire logic [1:0] found;

  // lookup and writable range
  assign found    = lookup(num, st, err, coils);
  assign hit      = found[1];
  assign rbit     = found[0];
  assign writable = (num >= `COIL_RUN && num <= `COIL_TRIP_RESET) ||
                    (num >= `COIL_VIN_FIRST && num <= `COIL_VIN_LAST);

endmodule

// *** rtl/coil_bank.sv ***
`timescale 1ns/1ps
`include "coil_bank_consts.svh"

module coil_bank #(
  parameter int NUM_VIN = 5
) (
  input  wire logic                            mclk,
  input  wire logic                            rst_n,
  input  wire logic                            ce,
  input  wire logic                            req_valid,
  input  wire coil_bank_pkg::request_type      req,
  input  wire coil_bank_pkg::device_status_type status,
  input  wire logic                            tripped,
  input  wire logic [NUM_VIN-1:0]              phys_terminals,
  input  wire logic                            reset_terminal,
  input  wire logic                            trip_event,
  input  wire coil_bank_pkg::comm_error_type    err_detect,
  input  wire logic [7:0]                      run_command_source_setting,
  input  wire logic [7:0]                      reset_selection_setting,
  output logic                                 rsp_valid,
  output coil_bank_pkg::answer_type            rsp,
  output logic                                 run_cmd,
  output logic                                 reverse_cmd,
  output logic                                 external_trip_req,
  output logic                                 reset_cmd,
  output logic [NUM_VIN-1:0]                   terminal_active,
  output logic [NUM_VIN-1:0]                   input_terminal_monitor,
  output logic                                 recalc_strobe,
  output coil_bank_pkg::comm_error_type        comm_errors
);

  coil_bank_pkg::coils_type  coils_q;
  coil_bank_pkg::coils_type  coils_d;
  coil_bank_pkg::answer_type rsp_q;
  coil_bank_pkg::answer_type rsp_d;
  logic                      rsp_valid_q;
  logic                      run_cmd_q;
  logic                      reverse_cmd_q;
  logic                      ext_trip_q;
  logic                      reset_cmd_q;
  logic [NUM_VIN-1:0]        active_q;
  logic [NUM_VIN-1:0]        monitor_q;
  logic                      recalc_q;

  wire logic [15:0]              item_num;
  wire coil_bank_pkg::access_type kind;
  wire logic                     read_hit;
  wire logic                     read_bit;
  wire logic                     writable;
  wire logic                     wval_ok;
  wire logic                     wval;
  wire logic [7:0]               exc_d;
  wire logic                     take;
  wire logic                     accept;
  wire logic                     coil_wr;
  wire logic                     recalc_d;
  wire logic                     reset_cmd_d;
  wire logic                     keep_on_reset;
  wire logic                     coil_clear;
  wire logic                     err_clear;
  wire logic                     comm_src;
  wire coil_bank_pkg::comm_error_type err_flags;

  // sets one writable coil to a value
  function automatic coil_bank_pkg::coils_type set_coil(input coil_bank_pkg::coils_type c,
                                                        input logic [15:0] n,
                                                        input logic v);
    coil_bank_pkg::coils_type r;
    logic [15:0]              vi;
    r  = c;
    vi = 16'(n - `COIL_VIN_FIRST);
    if (n == `COIL_RUN) begin
      r.run = v;
    end else if (n == `COIL_REVERSE) begin
      r.reverse = v;
    end else if (n == `COIL_EXT_TRIP) begin
      r.external_trip_coil = v;
    end else if (n == `COIL_TRIP_RESET) begin
      r.trip_reset_coil = v;
    end else begin
      r.vin[vi[2:0]] = v;
    end
    return r;
  endfunction

  // wire address to listed number
  assign item_num = 16'(req.addr + `ADDR_TO_NUMBER);

  // access kind from the function code
  assign kind = (req.func == `FUNC_READ_COILS) ? coil_bank_pkg::ACC_READ :
                (req.func == `FUNC_WRITE_COIL) ? coil_bank_pkg::ACC_WRITE_COIL :
                (req.func == `FUNC_WRITE_REG)  ? coil_bank_pkg::ACC_WRITE_REG :
                                                 coil_bank_pkg::ACC_BAD;

  // coil lookup, reads of all status coils
  coil_read_mux u_mux (
    .num      (item_num),
    .st       (status),
    .err      (err_flags),
    .coils    (coils_q),
    .hit      (read_hit),
    .rbit     (read_bit),
    .writable (writable)
  );

  // single-coil write value must be FF00h or 0000h
  assign wval_ok = (req.data == `COIL_ON_VALUE) || (req.data == `COIL_OFF_VALUE);
  assign wval    = (req.data == `COIL_ON_VALUE);

  // exception selection; only the recalculation register is writable, no store register
  assign exc_d =
    (kind == coil_bank_pkg::ACC_BAD) ? `EXC_FUNC :
    (kind == coil_bank_pkg::ACC_READ) ?
      (!read_hit ? `EXC_ADDR : (req.data != `READ_QUANTITY) ? `EXC_DATA : `EXC_NONE) :
    (kind == coil_bank_pkg::ACC_WRITE_COIL) ?
      (!writable ? `EXC_ADDR : !wval_ok ? `EXC_DATA : `EXC_NONE) :
    tripped ? `EXC_BUSY :
    (item_num != `REG_RECALC) ? `EXC_ADDR :
    (req.data != `RECALC_VALUE) ? `EXC_DATA :
    (status.running || status.undervoltage_flag) ? `EXC_BUSY :
    `EXC_NONE;

  // accepted requests and their effects
  assign take        = req_valid && ce;
  assign accept      = take && (exc_d == `EXC_NONE);
  assign coil_wr     = accept && (kind == coil_bank_pkg::ACC_WRITE_COIL);
  assign recalc_d    = accept && (kind == coil_bank_pkg::ACC_WRITE_REG);
  assign reset_cmd_d = reset_terminal ||
                       (coil_wr && item_num == `COIL_TRIP_RESET && wval);

  // reset input clears the coils unless the selection keeps them; reset beats a write
  assign keep_on_reset = (reset_selection_setting == `RESET_SEL_TRIP);
  assign coil_clear    = reset_terminal && !keep_on_reset;
  assign coils_d = coil_clear ? '0 :
                   coil_wr    ? set_coil(coils_q, item_num, wval) : coils_q;

  // error flags clear on reset command, or only on trip under selection 02
  assign err_clear = keep_on_reset ? trip_event : reset_cmd_d;

  comm_error_flags u_err (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .detect (err_detect),
    .clear  (err_clear),
    .flags  (err_flags)
  );

  // answer word
  assign rsp_d.ok       = (exc_d == `EXC_NONE);
  assign rsp_d.exc_code = exc_d;
  assign rsp_d.rbit     = (kind == coil_bank_pkg::ACC_READ) && read_hit && read_bit;

  // communication owns run and direction only with source setting 03
  assign comm_src = (run_command_source_setting == `RUN_SRC_COMM);

  // coil bank and answer registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coils_q     <= '0;
      rsp_q       <= '0;
      rsp_valid_q <= 1'b0;
    end else if (ce) begin
      coils_q     <= coils_d;
      rsp_q       <= take ? rsp_d : rsp_q;
      rsp_valid_q <= take;
    end
  end

  // command outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_cmd_q     <= 1'b0;
      reverse_cmd_q <= 1'b0;
      ext_trip_q    <= 1'b0;
      reset_cmd_q   <= 1'b0;
      recalc_q      <= 1'b0;
    end else if (ce) begin
      run_cmd_q     <= coils_d.run && comm_src;
      reverse_cmd_q <= coils_d.reverse && comm_src;
      ext_trip_q    <= coils_d.external_trip_coil;
      reset_cmd_q   <= reset_cmd_d;
      recalc_q      <= recalc_d;
    end
  end

  // terminal function and monitor
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_q  <= '0;
      monitor_q <= '0;
    end else if (ce) begin
      active_q  <= phys_terminals | coils_d.vin[NUM_VIN-1:0];
      monitor_q <= phys_terminals;
    end
  end

  assign rsp_valid              = rsp_valid_q;
  assign rsp                    = rsp_q;
  assign run_cmd                = run_cmd_q;
  assign reverse_cmd            = reverse_cmd_q;
  assign external_trip_req      = ext_trip_q;
  assign reset_cmd              = reset_cmd_q;
  assign terminal_active        = active_q;
  assign input_terminal_monitor = monitor_q;
  assign recalc_strobe          = recalc_q;
  assign comm_errors            = err_flags;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // recalculation strobe after a good trigger
  recalc_start_a: assert property (
    take && kind == coil_bank_pkg::ACC_WRITE_REG && item_num == `REG_RECALC &&
    req.data == `RECALC_VALUE && !tripped && !status.running &&
    !status.undervoltage_flag |=> recalc_strobe && rsp_valid && rsp.ok)
    else $error("recalculation trigger not carried out");

  // trigger refused while running
  recalc_busy_a: assert property (
    take && kind == coil_bank_pkg::ACC_WRITE_REG && item_num == `REG_RECALC &&
    req.data == `RECALC_VALUE && status.running
    |=> !recalc_strobe && rsp.exc_code == 8'h22)
    else $error("recalculation accepted while running");

  // register writes refused while tripped
  trip_write_a: assert property (
    take && kind == coil_bank_pkg::ACC_WRITE_REG && tripped |=> rsp.exc_code == 8'h22 && !rsp.ok)
    else $error("register write accepted while tripped");

  // run and direction gated by source setting
  run_gate_a: assert property (
    ce && !comm_src |=> !run_cmd)
    else $error("run command without communication source");
  dir_gate_a: assert property (
    ce && !comm_src |=> !reverse_cmd)
    else $error("direction command without communication source");

  // terminals OR, monitor physical only
  vin_or_a: assert property (
    ce |=> (terminal_active & $past(phys_terminals)) == $past(phys_terminals))
    else $error("physical terminal lost from active set");
  monitor_phys_a: assert property (
    ce |=> input_terminal_monitor == $past(phys_terminals))
    else $error("terminal monitor shows virtual inputs");

  // reset input clears or keeps the coils
  reset_clear_a: assert property (
    ce && reset_terminal && !keep_on_reset |=> coils_q == '0 && !external_trip_req)
    else $error("writable coils not cleared by reset");
  reset_keep_a: assert property (
    ce && reset_terminal && keep_on_reset && !coil_wr |=> coils_q == $past(coils_q))
    else $error("writable coils cleared under selection 02");

  // error flags hold without a clearing event
  err_sticky_a: assert property (
    ce && !err_clear |=> (comm_errors & $past(comm_errors)) == $past(comm_errors))
    else $error("communication error flag dropped");
  err_trip_only_a: assert property (
    ce && keep_on_reset && !trip_event |=> (comm_errors & $past(comm_errors)) ==
    $past(comm_errors))
    else $error("error flag cleared without trip under selection 02");

  // external trip follows its coil write
  ext_trip_a: assert property (
    coil_wr && item_num == `COIL_EXT_TRIP && wval && !coil_clear |=> external_trip_req)
    else $error("external trip coil did not trip");

  // wire address zero reads the run coil; number zero is refused
  addr_offset_a: assert property (
    take && kind == coil_bank_pkg::ACC_READ && req.addr == 16'h0000 &&
    req.data == `READ_QUANTITY |=> rsp.ok && rsp.rbit == $past(coils_q.run))
    else $error("address offset wrong");
  reserved_a: assert property (
    take && item_num == 16'h0000 |=> !rsp.ok)
    else $error("reserved coil accepted");

endmodule

// *** testbench/modbus_master_model.sv ***
`timescale 1ns/1ps
`include "coil_bank_consts.svh"

// modbus master stand-in: one request at a time, answer taken one edge later
module modbus_master_model (
  input  wire logic                      mclk,
  output logic                           req_valid,
  output coil_bank_pkg::request_type     req,
  input  wire logic                      rsp_valid,
  input  wire coil_bank_pkg::answer_type rsp
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // listed number goes out one lower on the wire; released lines carry junk
  task automatic xfer(input logic [7:0] f, input logic [15:0] n, input logic [15:0] d,
                      output coil_bank_pkg::answer_type r);
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{func: f, addr: n - `ADDR_TO_NUMBER, data: d};
    @(posedge mclk);
    req_valid <= 1'b0;
    req <= ~req;
    #1;
    r = (rsp_valid === 1'b1) ? rsp :
        coil_bank_pkg::answer_type'{ok: 1'b0, exc_code: 8'hFF, rbit: 1'b0};
  endtask

  // recalculation, sent after motor or curve parameters change
  task automatic recalc(output coil_bank_pkg::answer_type r);
    xfer(`FUNC_WRITE_REG, `REG_RECALC, `RECALC_VALUE, r);
  endtask
endmodule

// *** testbench/tb_modbus_coil_bank_and_recalc.sv ***
`timescale 1ns/1ps
`include "coil_bank_consts.svh"

module tb_modbus_coil_bank_and_recalc;
  logic                             mclk, rst_n, ce, req_valid, tripped, rsp_valid;
  logic                             reset_terminal, trip_event, run_cmd, reverse_cmd;
  logic                             external_trip_req, reset_cmd, recalc_strobe;
  logic [4:0]                       phys_terminals, terminal_active, input_terminal_monitor;
  logic [7:0]                       run_command_source_setting, reset_selection_setting;
  coil_bank_pkg::request_type       req;
  coil_bank_pkg::answer_type        rsp, a;
  coil_bank_pkg::device_status_type status;
  coil_bank_pkg::comm_error_type    err_detect, comm_errors;
  int                               num_errors, checks;

  coil_bank dut (.mclk, .rst_n, .ce, .req_valid, .req, .status, .tripped, .phys_terminals,
    .reset_terminal, .trip_event, .err_detect, .run_command_source_setting,
    .reset_selection_setting, .rsp_valid, .rsp, .run_cmd, .reverse_cmd, .external_trip_req,
    .reset_cmd, .terminal_active, .input_terminal_monitor, .recalc_strobe, .comm_errors);
  modbus_master_model m (.mclk, .req_valid, .req, .rsp_valid, .rsp);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] n, input logic v);
    m.xfer(`FUNC_WRITE_COIL, n, v ? `COIL_ON_VALUE : `COIL_OFF_VALUE, a);
  endtask

  // read one coil; bit and ok flag compared together
  task automatic rd(input logic [15:0] n, input logic e);
    m.xfer(`FUNC_READ_COILS, n, `READ_QUANTITY, a);
    chk("coil", {e, 1'b1}, {a.rbit, a.ok});
  endtask

  // one-cycle pulse: 0 reset terminal, 1 trip, 2 all error detections
  task automatic pulse(input int k);
    @(posedge mclk);
    reset_terminal <= (k == 0);
    trip_event <= (k == 1);
    err_detect <= (k == 2) ? 4'hF : 4'h0;
    @(posedge mclk);
    {reset_terminal, trip_event, err_detect} <= '0;
    #1;
  endtask

  task automatic t_cmd;
    wr(`COIL_RUN, 1'b1);
    wr(`COIL_REVERSE, 1'b1);
    chk("cmd", 2'b11, {run_cmd, reverse_cmd});
    rd(`COIL_RUN, 1'b1);
    @(posedge mclk);
    run_command_source_setting <= 8'h01;
    @(posedge mclk);
    run_command_source_setting <= `RUN_SRC_COMM;
    #1;
    chk("cmd", 2'b00, {run_cmd, reverse_cmd});
    wr(`COIL_EXT_TRIP, 1'b1);
    chk("trip", 1'b1, external_trip_req);
    rd(`COIL_EXT_TRIP, 1'b1);
    wr(`COIL_VIN_FIRST, 1'b1);
    chk("vin", {5'h01, 5'h00}, {terminal_active, input_terminal_monitor});
    @(posedge mclk);
    phys_terminals <= 5'h10;
    repeat (2) @(posedge mclk);
    #1;
    chk("vin", {5'h11, 5'h10}, {terminal_active, input_terminal_monitor});
    $display("done commands");
  endtask

  task automatic t_reset;
    pulse(0);
    chk("clr", 9'h110, {reset_cmd, run_cmd, reverse_cmd, external_trip_req, terminal_active});
    wr(`COIL_RUN, 1'b1);
    @(posedge mclk);
    reset_selection_setting <= `RESET_SEL_TRIP;
    pulse(0);
    chk("keep", 1'b1, run_cmd);
    pulse(2);
    pulse(0);
    chk("err", 4'hF, comm_errors);
    pulse(1);
    chk("err", 4'h0, comm_errors);
    @(posedge mclk);
    reset_selection_setting <= 8'h00;
    wr(`COIL_RUN, 1'b0);
    $display("done reset");
  endtask

  task automatic t_err;
    // one detection at a time, so each flag must land on its own coil
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      err_detect <= 4'h8 >> i;
      @(posedge mclk);
      err_detect <= 4'h0;
      rd(16'(`COIL_ERR_CRC + i), 1'b1);
      rd(16'(`COIL_ERR_CRC + (i + 1) % 4), 1'b0);
      wr(`COIL_TRIP_RESET, 1'b1);
    end
    pulse(2);
    wr(`COIL_TRIP_RESET, 1'b1);
    repeat (2) @(posedge mclk);
    #1;
    chk("err", 4'h0, comm_errors);
    $display("done errors");
  endtask

  task automatic t_recalc;
    m.recalc(a);
    chk("recalc", 2'b11, {a.ok, recalc_strobe});
    @(posedge mclk);
    {status.running, tripped} <= 2'b10;
    m.recalc(a);
    chk("busy", {1'b0, `EXC_BUSY}, {a.ok, a.exc_code});
    @(posedge mclk);
    {status.running, tripped} <= 2'b01;
    m.recalc(a);
    chk("busy", {1'b0, `EXC_BUSY, 1'b0}, {a.ok, a.exc_code, recalc_strobe});
    @(posedge mclk);
    tripped <= 1'b0;
    m.xfer(`FUNC_READ_COILS, 16'h0000, `READ_QUANTITY, a);
    chk("resv", {1'b0, `EXC_ADDR}, {a.ok, a.exc_code});
    m.xfer(`FUNC_WRITE_COIL, 16'h0005, `COIL_ON_VALUE, a);
    chk("resv", {1'b0, `EXC_ADDR}, {a.ok, a.exc_code});
    m.xfer(`FUNC_WRITE_COIL, `COIL_RUN, 16'h1234, a);
    chk("bit", {1'b0, `EXC_DATA}, {a.ok, a.exc_code});
    m.xfer(`FUNC_WRITE_REG, 16'h0902, `RECALC_VALUE, a);
    chk("store", {1'b0, `EXC_ADDR, 1'b0}, {a.ok, a.exc_code, recalc_strobe});
    $display("done recalc");
  endtask

  task automatic t_status;
    logic [15:0] tbl [26] = '{16'h000F, 16'h0010, 16'h0011, 16'h0013, 16'h0014, 16'h0015,
      16'h0016, 16'h0017, 16'h0018, 16'h0019, 16'h001C, 16'h001E, 16'h001F, 16'h0020,
      16'h0028, 16'h002E, 16'h003C, 16'h003D, 16'h003E, 16'h0046, 16'h0047, 16'h0048,
      16'h0050, 16'h0054, 16'h0055, 16'h0056};
    for (int i = 0; i < 26; i++) begin
      @(posedge mclk);
      status <= 26'h1 << (25 - i);
      rd(tbl[i], 1'b1);
      rd(tbl[(i + 1) % 26], 1'b0);
      if (i == 2) rd(16'h0045, 1'b1);
    end
    $display("done status");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {rst_n, tripped, reset_terminal, trip_event, phys_terminals, status} = '0;
    {err_detect, reset_selection_setting, num_errors, checks} = '0;
    ce = 1'b1;
    run_command_source_setting = `RUN_SRC_COMM;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_cmd();
    t_reset();
    t_err();
    t_recalc();
    t_status();
    conclude();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    conclude();
  end
endmodule
